// file: verilog/mtr_resolver.sv
`timescale 1ns/1ns
module mtr_resolver
  import mtr_pkg::*;
#(
  parameter int NVAR             = 4,
  parameter int PA_W             = 40,
  parameter bit TYPING_SUPPORTED = 1'b1
)(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pat_load,
  input  wire logic [63:0]       pat_table,
  input  wire logic              req_valid,
  input  wire mtr_kind_t         req_kind,
  input  wire mtr_pgsz_t         req_page_size,
  input  wire logic              req_ctx_cd,
  input  wire logic              req_ctx_wt,
  input  wire logic [ENTRY_W-1:0] req_parent_entry,
  input  wire logic [ENTRY_W-1:0] req_leaf_entry,
  input  wire logic [PA_W-1:0]   req_pa,
  output logic                   rsp_valid,
  output mtr_mtype_t             rsp_pat_type,
  output mtr_mtype_t             rsp_range_type,
  output mtr_mtype_t             rsp_eff_type
);

  localparam int PG_W = PA_W - PAGE_LSB;
  localparam int HI_W = PA_W - 32;
  localparam logic [11:0] OFF_FIX_END = OFF_FIX + 12'(4 * FIX_WORDS);
  localparam logic [11:0] OFF_VAR_END = OFF_VAR + 12'(VAR_STRIDE * NVAR);

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CAP  = 3'h1,
    SEL_DEF  = 3'h2,
    SEL_STAT = 3'h3,
    SEL_FIX  = 3'h4,
    SEL_VAR  = 3'h5
  } mtr_selkind_t;

  typedef struct packed {
    mtr_selkind_t kind;
    logic [7:0]   idx;
    logic [1:0]   word;
  } mtr_sel_t;

  typedef struct packed {
    logic                         aw_rdy;
    logic                         w_rdy;
    logic                         ar_rdy;
    logic [11:0]                  aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         b_vld;
    logic [1:0]                   b_resp;
    logic                         r_vld;
    logic [1:0]                   r_resp;
    logic [31:0]                  r_data;
    logic [31:0]                  def_type;
    logic [FIX_WORDS-1:0][31:0]   fix_range;
    logic [NVAR-1:0][31:0]        vbase_lo;
    logic [NVAR-1:0][31:0]        vbase_hi;
    logic [NVAR-1:0][31:0]        vmask_lo;
    logic [NVAR-1:0][31:0]        vmask_hi;
    logic [63:0]                  pat_copy;
    logic                         rsp_vld;
    mtr_mtype_t                   rsp_pat;
    mtr_mtype_t                   rsp_rng;
    mtr_mtype_t                   rsp_eff;
  } mtr_state_t;

  mtr_state_t state_reg;
  mtr_state_t state_next;

  logic [2:0]  pat_idx;
  mtr_mtype_t  pat_type;
  mtr_mtype_t  range_type;
  mtr_mtype_t  eff_type;
  logic [63:0] pat_use;

  // typing registers only decode when support is built in
  function automatic mtr_sel_t decode(input logic [11:0] a);
    logic [11:0] off;
    mtr_sel_t    s;
    off    = '0;
    s.kind = SEL_NONE;
    s.idx  = '0;
    s.word = '0;
    if (a == OFF_CAP) begin
      s.kind = SEL_CAP;
    end else if (a == OFF_STAT) begin
      s.kind = SEL_STAT;
    end else if (TYPING_SUPPORTED && a == OFF_DEF) begin
      s.kind = SEL_DEF;
    end else if (TYPING_SUPPORTED && a >= OFF_FIX && a < OFF_FIX_END
                 && a[1:0] == 2'h0) begin
      off    = a - OFF_FIX;
      s.kind = SEL_FIX;
      s.idx  = {1'b0, off[8:2]};
    end else if (TYPING_SUPPORTED && a >= OFF_VAR && a < OFF_VAR_END
                 && a[1:0] == 2'h0) begin
      off    = a - OFF_VAR;
      s.kind = SEL_VAR;
      s.idx  = off[11:4];
      s.word = off[3:2];
    end
    return s;
  endfunction : decode

  // the context's attribute table is held until the walker reloads it,
  // so a changed context entry takes effect from the reload cycle on, as pat_load passes pat_table straight through
  assign pat_use = pat_load ? pat_table : state_reg.pat_copy;

  always_comb begin
    logic attr_bit;
    logic cd_bit;
    logic wt_bit;
    attr_bit = (req_page_size == PG_4K) ? req_leaf_entry[ATTR_BIT_SMALL]
                                        : req_leaf_entry[ATTR_BIT_LARGE];
    cd_bit   = req_leaf_entry[CD_BIT];
    wt_bit   = req_leaf_entry[WT_BIT];
    pat_idx  = 3'h0;
    unique case (req_kind)
      KIND_TOP:     pat_idx = {1'b0, req_ctx_cd, req_ctx_wt};
      KIND_NONLEAF: pat_idx = {1'b0, req_parent_entry[CD_BIT],
                               req_parent_entry[WT_BIT]};
      KIND_FINAL:   pat_idx = {attr_bit, cd_bit, wt_bit};
      default:      pat_idx = 3'h0;
    endcase
    pat_type = to_mtype(pat_use[PAT_ENTRY_W*pat_idx +: 3]);
  end

  always_comb begin
    logic [PG_W-1:0] pa_pg;
    logic [PG_W-1:0] vb;
    logic [PG_W-1:0] vm;
    logic [6:0]      fidx;
    logic [19:0]     low;
    logic            any_hit;
    logic            any_uc;
    logic            all_same;
    logic            only_wtwb;
    mtr_mtype_t      first_t;
    mtr_mtype_t      cur_t;
    pa_pg     = req_pa[PA_W-1:PAGE_LSB];
    vb        = '0;
    vm        = '0;
    low       = req_pa[FIX_SPAN_W-1:0];
    fidx      = '0;
    any_hit   = 1'b0;
    any_uc    = 1'b0;
    all_same  = 1'b1;
    only_wtwb = 1'b1;
    first_t   = MT_UC;
    cur_t     = MT_UC;
    if (low < FIX64K_LIMIT) begin
      fidx = {4'h0, low[18:16]};
    end else if (low < FIX16K_LIMIT) begin
      fidx = FIX16K_BASE + {3'h0, low[17:14]};
    end else begin
      fidx = FIX4K_BASE + {1'b0, low[17:12]};
    end
    for (int n = 0; n < NVAR; n++) begin
      vb = {state_reg.vbase_hi[n][HI_W-1:0],
            state_reg.vbase_lo[n][31:PAGE_LSB]};
      vm = {state_reg.vmask_hi[n][HI_W-1:0],
            state_reg.vmask_lo[n][31:PAGE_LSB]};
      cur_t = to_mtype(state_reg.vbase_lo[n][2:0]);
      if (state_reg.vmask_lo[n][MASK_V_BIT] && (pa_pg & vm) == (vb & vm)) begin
        if (!any_hit) begin
          first_t = cur_t;
        end else if (cur_t != first_t) begin
          all_same = 1'b0;
        end
        any_hit   = 1'b1;
        any_uc    = any_uc | (cur_t == MT_UC);
        only_wtwb = only_wtwb & (cur_t == MT_WT || cur_t == MT_WB);
      end
    end
    if (!TYPING_SUPPORTED) begin
      // without range typing the range counts as write-back: the attribute type passes through, except that UC- becomes UC
      range_type = MT_WB;
    end else if (!state_reg.def_type[DEF_E_BIT]) begin
      range_type = MT_UC;
    end else if (req_pa[PA_W-1:FIX_SPAN_W] == '0
                 && state_reg.def_type[DEF_FE_BIT]) begin
      range_type = to_mtype(
        state_reg.fix_range[fidx[6:2]][8*fidx[1:0] +: 3]);
    end else if (!any_hit) begin
      range_type = to_mtype(state_reg.def_type[DEF_TYPE_LSB +: 3]);
    end else if (any_uc) begin
      range_type = MT_UC;
    end else if (all_same) begin
      range_type = first_t;
    end else if (only_wtwb) begin
      range_type = MT_WT;
    end else begin
      // overlap outside the defined cases: pick the safe type
      range_type = MT_UC;
    end
  end

  mtr_eff_combine u_combine (
    .range_type (range_type),
    .pat_type   (pat_type),
    .eff_type   (eff_type)
  );

  always_comb begin
    mtr_sel_t    ws;
    mtr_sel_t    rs;
    logic [31:0] rd;
    logic [31:0] cur;
    state_next = state_reg;
    ws         = decode(state_reg.aw_addr);
    rs         = decode(s_axi_araddr);
    rd         = '0;
    cur        = '0;

    if (pat_load) begin
      state_next.pat_copy = pat_table;
    end
    state_next.rsp_vld = req_valid;
    if (req_valid) begin
      state_next.rsp_pat = pat_type;
      state_next.rsp_rng = range_type;
      state_next.rsp_eff = eff_type;
    end

    // write address and data are taken in either order, then committed
    if (s_axi_awvalid && state_reg.aw_rdy) begin
      state_next.aw_addr = s_axi_awaddr;
      state_next.aw_rdy  = 1'b0;
    end
    if (s_axi_wvalid && state_reg.w_rdy) begin
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
      state_next.w_rdy  = 1'b0;
    end
    if (!state_reg.aw_rdy && !state_reg.w_rdy && !state_reg.b_vld) begin
      state_next.b_vld  = 1'b1;
      state_next.b_resp = RESP_OKAY;
      unique case (ws.kind)
        SEL_DEF: begin
          state_next.def_type = apply_strb(state_reg.def_type,
                                           state_reg.w_data,
                                           state_reg.w_strb);
        end
        SEL_FIX: begin
          state_next.fix_range[ws.idx[4:0]] =
            apply_strb(state_reg.fix_range[ws.idx[4:0]],
                       state_reg.w_data, state_reg.w_strb);
        end
        SEL_VAR: begin
          unique case (ws.word)
            2'h0: begin
              cur = state_reg.vbase_lo[ws.idx];
              state_next.vbase_lo[ws.idx] =
                apply_strb(cur, state_reg.w_data, state_reg.w_strb);
            end
            2'h1: begin
              cur = state_reg.vbase_hi[ws.idx];
              state_next.vbase_hi[ws.idx] =
                apply_strb(cur, state_reg.w_data, state_reg.w_strb);
            end
            2'h2: begin
              cur = state_reg.vmask_lo[ws.idx];
              state_next.vmask_lo[ws.idx] =
                apply_strb(cur, state_reg.w_data, state_reg.w_strb);
            end
            default: begin
              cur = state_reg.vmask_hi[ws.idx];
              state_next.vmask_hi[ws.idx] =
                apply_strb(cur, state_reg.w_data, state_reg.w_strb);
            end
          endcase
        end
        // capability and status are read-only; writes are acknowledged
        SEL_CAP, SEL_STAT: state_next.b_resp = RESP_OKAY;
        default:           state_next.b_resp = RESP_SLVERR;
      endcase
    end
    if (state_reg.b_vld && s_axi_bready) begin
      state_next.b_vld  = 1'b0;
      state_next.aw_rdy = 1'b1;
      state_next.w_rdy  = 1'b1;
    end

    if (s_axi_arvalid && state_reg.ar_rdy) begin
      unique case (rs.kind)
        SEL_CAP: begin
          rd[CAP_VCNT_LSB +: 8] = 8'(NVAR);
          rd[CAP_FIX_BIT]       = TYPING_SUPPORTED;
          rd[CAP_SUP_BIT]       = TYPING_SUPPORTED;
        end
        SEL_STAT: begin
          rd[STAT_EFF_LSB +: 3] = state_reg.rsp_eff;
          rd[STAT_PAT_LSB +: 3] = state_reg.rsp_pat;
          rd[STAT_RNG_LSB +: 3] = state_reg.rsp_rng;
        end
        SEL_DEF: rd = state_reg.def_type;
        SEL_FIX: rd = state_reg.fix_range[rs.idx[4:0]];
        SEL_VAR: begin
          unique case (rs.word)
            2'h0:    rd = state_reg.vbase_lo[rs.idx];
            2'h1:    rd = state_reg.vbase_hi[rs.idx];
            2'h2:    rd = state_reg.vmask_lo[rs.idx];
            default: rd = state_reg.vmask_hi[rs.idx];
          endcase
        end
        default: rd = '0;
      endcase
      state_next.r_data = rd;
      state_next.r_resp = (rs.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      state_next.r_vld  = 1'b1;
      state_next.ar_rdy = 1'b0;
    end
    if (state_reg.r_vld && s_axi_rready) begin
      state_next.r_vld  = 1'b0;
      state_next.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg          <= '0;
      state_reg.aw_rdy   <= 1'b1;
      state_reg.w_rdy    <= 1'b1;
      state_reg.ar_rdy   <= 1'b1;
      state_reg.def_type <= DEF_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready  = state_reg.aw_rdy;
  assign s_axi_wready   = state_reg.w_rdy;
  assign s_axi_bvalid   = state_reg.b_vld;
  assign s_axi_bresp    = state_reg.b_resp;
  assign s_axi_arready  = state_reg.ar_rdy;
  assign s_axi_rvalid   = state_reg.r_vld;
  assign s_axi_rresp    = state_reg.r_resp;
  assign s_axi_rdata    = state_reg.r_data;
  assign rsp_valid      = state_reg.rsp_vld;
  assign rsp_pat_type   = state_reg.rsp_pat;
  assign rsp_range_type = state_reg.rsp_rng;
  assign rsp_eff_type   = state_reg.rsp_eff;

endmodule : mtr_resolver

// file: verilog/mtr_pkg.sv
package mtr_pkg;

  typedef enum logic [2:0] {
    MT_UC  = 3'h0,
    MT_WC  = 3'h1,
    MT_WT  = 3'h4,
    MT_WP  = 3'h5,
    MT_WB  = 3'h6,
    MT_UCM = 3'h7
  } mtr_mtype_t;

  typedef enum logic [1:0] {
    KIND_TOP    = 2'h0,
    KIND_NONLEAF = 2'h1,
    KIND_FINAL  = 2'h2
  } mtr_kind_t;

  typedef enum logic [1:0] {
    PG_4K = 2'h0,
    PG_2M = 2'h1,
    PG_1G = 2'h2
  } mtr_pgsz_t;

  localparam int ENTRY_W        = 13;
  localparam int ATTR_BIT_SMALL = 7;
  localparam int ATTR_BIT_LARGE = 12;
  localparam int CD_BIT         = 4;
  localparam int WT_BIT         = 3;
  localparam int PAT_ENTRY_W    = 8;

  localparam logic [11:0] OFF_CAP  = 12'h000;
  localparam logic [11:0] OFF_DEF  = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_FIX  = 12'h100;
  localparam logic [11:0] OFF_VAR  = 12'h200;
  localparam int          FIX_WORDS  = 22;
  localparam int          VAR_STRIDE = 16;

  localparam int CAP_VCNT_LSB  = 0;
  localparam int CAP_FIX_BIT   = 8;
  localparam int CAP_SUP_BIT   = 31;
  localparam int DEF_TYPE_LSB  = 0;
  localparam int DEF_FE_BIT    = 10;
  localparam int DEF_E_BIT     = 11;
  localparam logic [31:0] DEF_RST = 32'h0000_0000;
  localparam int STAT_EFF_LSB  = 0;
  localparam int STAT_PAT_LSB  = 4;
  localparam int STAT_RNG_LSB  = 8;
  localparam int MASK_V_BIT    = 11;
  localparam int PAGE_LSB      = 12;

  localparam int          FIX_SPAN_W    = 20;
  localparam logic [19:0] FIX64K_LIMIT  = 20'h80000;
  localparam logic [19:0] FIX16K_LIMIT  = 20'hC0000;
  localparam logic [6:0]  FIX16K_BASE   = 7'h08;
  localparam logic [6:0]  FIX4K_BASE    = 7'h18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // codes 2 and 3 are reserved; they are treated as uncacheable
  function automatic mtr_mtype_t to_mtype(input logic [2:0] code);
    case (code)
      3'h1:    to_mtype = MT_WC;
      3'h4:    to_mtype = MT_WT;
      3'h5:    to_mtype = MT_WP;
      3'h6:    to_mtype = MT_WB;
      3'h7:    to_mtype = MT_UCM;
      default: to_mtype = MT_UC;
    endcase
  endfunction : to_mtype

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      apply_strb[8*b +: 8] = strb[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
  endfunction : apply_strb

endpackage : mtr_pkg

// file: verilog/mtr_eff_combine.sv
`timescale 1ns/1ns
module mtr_eff_combine
  import mtr_pkg::*;
(
  input  mtr_mtype_t range_type,
  input  mtr_mtype_t pat_type,
  output mtr_mtype_t eff_type
);

  always_comb begin
    eff_type = MT_UC;
    unique case (range_type)
      MT_WC: begin
        case (pat_type)
          MT_UCM, MT_WC, MT_WB: eff_type = MT_WC;
          default:              eff_type = MT_UC;
        endcase
      end
      MT_WT: begin
        case (pat_type)
          MT_WC:        eff_type = MT_WC;
          MT_WT, MT_WB: eff_type = MT_WT;
          MT_WP:        eff_type = MT_WP;
          default:      eff_type = MT_UC;
        endcase
      end
      MT_WB: begin
        case (pat_type)
          MT_UC, MT_UCM: eff_type = MT_UC;
          default:       eff_type = pat_type;
        endcase
      end
      MT_WP: begin
        case (pat_type)
          MT_UCM, MT_WC: eff_type = MT_WC;
          MT_WT:         eff_type = MT_WT;
          MT_WB, MT_WP:  eff_type = MT_WP;
          default:       eff_type = MT_UC;
        endcase
      end
      // range type UC, or UC- from range type code 7, which merges the same as UC
      default: eff_type = (pat_type == MT_WC) ? MT_WC : MT_UC;
    endcase
  end

endmodule : mtr_eff_combine

// file: sim/mtr_walker_model.sv
`timescale 1ns/1ns
module mtr_walker_model
  import mtr_pkg::*;
#(
  parameter int PA_W = 40
)(
  input  wire logic           clk_sys,
  output logic                pat_load,
  output logic [63:0]         pat_table,
  output logic                req_valid,
  output mtr_kind_t           req_kind,
  output mtr_pgsz_t           req_page_size,
  output logic                req_ctx_cd,
  output logic                req_ctx_wt,
  output logic [ENTRY_W-1:0]  req_parent_entry,
  output logic [ENTRY_W-1:0]  req_leaf_entry,
  output logic [PA_W-1:0]     req_pa
);
  initial begin
    pat_load = 1'b0;
    pat_table = '0;
    req_valid = 1'b0;
    req_kind = KIND_TOP;
    req_page_size = PG_4K;
    {req_ctx_cd, req_ctx_wt} = 2'h0;
    req_parent_entry = '0;
    req_leaf_entry = '0;
    req_pa = '0;
  end

  task automatic send(input mtr_kind_t k, input mtr_pgsz_t s,
                      input logic [1:0] c, input logic [ENTRY_W-1:0] p,
                      input logic [ENTRY_W-1:0] l, input logic [PA_W-1:0] a);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_page_size <= s;
    {req_ctx_cd, req_ctx_wt} <= c;
    req_parent_entry <= p;
    req_leaf_entry <= l;
    req_pa <= a;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // stale fields flip so a late sample cannot pass by luck
    {req_ctx_cd, req_ctx_wt} <= ~c;
    req_parent_entry <= ~p;
    req_leaf_entry <= ~l;
    req_pa <= ~a;
  endtask : send

  task automatic load(input logic [63:0] t);
    @(posedge clk_sys);
    pat_load <= 1'b1;
    pat_table <= t;
    @(posedge clk_sys);
    pat_load <= 1'b0;
    pat_table <= ~t;
  endtask : load
endmodule : mtr_walker_model

// file: sim/mtr_resolver_chk.sv
`timescale 1ns/1ns
module mtr_resolver_chk
  import mtr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        req_valid,
  input wire logic        rsp_valid,
  input wire mtr_mtype_t  rsp_pat_type,
  input wire mtr_mtype_t  rsp_range_type,
  input wire mtr_mtype_t  rsp_eff_type
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  rsp_follow_a: assert property (req_valid |=> rsp_valid)
    else $error("no response after request");
  rsp_quiet_a: assert property (!req_valid |=> !rsp_valid)
    else $error("response without request");
  type_hold_a: assert property (!req_valid |=>
    $stable(rsp_eff_type) && $stable(rsp_range_type))
    else $error("types moved without request");
  range_code_a: assert property (rsp_valid |-> rsp_range_type != MT_UCM)
    else $error("range type is weak uncacheable");
  uc_row_a: assert property (rsp_valid && rsp_range_type == MT_UC |->
    rsp_eff_type == (rsp_pat_type == MT_WC ? MT_WC : MT_UC))
    else $error("bad merge for uncacheable range");
  wc_row_a: assert property (rsp_valid && rsp_range_type == MT_WC |->
    rsp_eff_type == (rsp_pat_type inside {MT_UC, MT_WT, MT_WP} ? MT_UC : MT_WC))
    else $error("bad merge for combining range");
  wt_row_a: assert property (rsp_valid && rsp_range_type == MT_WT |->
    rsp_eff_type == (rsp_pat_type inside {MT_UC, MT_UCM} ? MT_UC :
                     rsp_pat_type == MT_WB ? MT_WT : rsp_pat_type))
    else $error("bad merge for write-through range");
  wb_row_a: assert property (rsp_valid && rsp_range_type == MT_WB |->
    rsp_eff_type == (rsp_pat_type == MT_UCM ? MT_UC : rsp_pat_type))
    else $error("bad merge for write-back range");
  wp_row_a: assert property (rsp_valid && rsp_range_type == MT_WP |->
    rsp_eff_type == (rsp_pat_type == MT_UC ? MT_UC :
                     rsp_pat_type inside {MT_UCM, MT_WC} ? MT_WC :
                     rsp_pat_type == MT_WB ? MT_WP : rsp_pat_type))
    else $error("bad merge for protected range");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");

  wt_seen_c: cover property (rsp_valid && rsp_range_type == MT_WT);
  wp_seen_c: cover property (rsp_valid && rsp_range_type == MT_WP);
  wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule : mtr_resolver_chk

bind mtr_resolver mtr_resolver_chk u_mtr_resolver_chk (.*);

// file: sim/tb.sv
`timescale 1ns/1ns
module tb
  import mtr_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rsp_valid;
  logic        pat_load, req_valid, cd, wt;
  logic [1:0]  bresp, rresp;
  logic [63:0] ptab;
  logic [12:0] par, leaf;
  logic [39:0] pa;
  mtr_kind_t   kind;
  mtr_pgsz_t   psz;
  mtr_mtype_t  pt, rt, et;
  int          err_count = 0;
  int          n_checks = 0;
  mtr_mtype_t  tbl [8] = '{MT_UC, MT_WC, MT_WT, MT_WP, MT_WB, MT_UCM,
                           MT_WT, MT_WC};

  always #2 clk_sys = ~clk_sys;

  mtr_resolver u_mtr_resolver (.clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pat_load(pat_load),
    .pat_table(ptab), .req_valid(req_valid), .req_kind(kind),
    .req_page_size(psz), .req_ctx_cd(cd), .req_ctx_wt(wt),
    .req_parent_entry(par), .req_leaf_entry(leaf), .req_pa(pa),
    .rsp_valid(rsp_valid), .rsp_pat_type(pt), .rsp_range_type(rt),
    .rsp_eff_type(et));

  mtr_walker_model u_mtr_walker_model (.clk_sys(clk_sys),
    .pat_load(pat_load), .pat_table(ptab), .req_valid(req_valid),
    .req_kind(kind), .req_page_size(psz), .req_ctx_cd(cd), .req_ctx_wt(wt),
    .req_parent_entry(par), .req_leaf_entry(leaf), .req_pa(pa));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] e);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rq(input mtr_kind_t k, input mtr_pgsz_t s,
                    input logic [1:0] c, input logic [12:0] p,
                    input logic [12:0] l, input logic [39:0] a);
    u_mtr_walker_model.send(k, s, c, p, l, a);
    #1;
    chk(rsp_valid, 1'b1);
  endtask : rq

  // attribute bit lands on bit 7 or 12, the other one carries its inverse
  function automatic logic [12:0] lf(input logic [2:0] i, input logic big);
    return {big ? i[2] : ~i[2], 4'h0, big ? ~i[2] : i[2], 2'h0, i[1:0], 3'h0};
  endfunction : lf

  function automatic mtr_mtype_t mrg(input mtr_mtype_t r, input mtr_mtype_t p);
    case (r)
      MT_UC: return p == MT_WC ? MT_WC : MT_UC;
      MT_WC: return p inside {MT_UC, MT_WT, MT_WP} ? MT_UC : MT_WC;
      MT_WT: return p inside {MT_UC, MT_UCM} ? MT_UC : p == MT_WB ? MT_WT : p;
      MT_WB: return p == MT_UCM ? MT_UC : p;
      default: return p == MT_UC ? MT_UC : p inside {MT_UCM, MT_WC} ? MT_WC :
                      p == MT_WB ? MT_WP : p;
    endcase
  endfunction : mrg

  task automatic t_reset();
    logic [31:0] v;
    logic [1:0]  e;
    rd(OFF_CAP, v, e);
    chk(v, 32'h8000_0104);
    rd(OFF_DEF, v, e);
    chk(v, DEF_RST);
    rd(12'h0FC, v, e);
    chk(e, RESP_SLVERR);
    wr(12'h0FC, 32'h0000_0000, RESP_SLVERR);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, 13'h0098, 40'h00_1000_0000);
    chk(rt, MT_UC);
    chk(pt, MT_UC);
  endtask : t_reset

  task automatic t_index();
    logic [63:0] t;
    for (int i = 0; i < 8; i++) t[8*i +: 8] = {5'h00, tbl[i]};
    u_mtr_walker_model.load(t);
    for (int i = 0; i < 4; i++) begin
      rq(KIND_TOP, PG_4K, i[1:0], 13'h1FFF, 13'h1FFF, '0);
      chk(pt, tbl[i]);
      rq(KIND_NONLEAF, PG_4K, ~i[1:0], lf({1'b0, i[1:0]}, 1'b0), '0, '0);
      chk(pt, tbl[i]);
    end
    for (int i = 0; i < 8; i++) begin
      for (int s = 0; s < 3; s++) begin
        rq(KIND_FINAL, mtr_pgsz_t'(s), 2'h3, lf(~i[2:0], s != 0),
           lf(i[2:0], s != 0), '0);
        chk(pt, tbl[i]);
      end
    end
  endtask : t_index

  task automatic t_range();
    wr(OFF_DEF, 32'h0000_0C06, RESP_OKAY);
    wr(OFF_FIX, 32'h0000_0004, RESP_OKAY);
    wr(OFF_FIX + 12'h008, 32'h0000_0005, RESP_OKAY);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_0000_0100);
    chk(rt, MT_WT);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_0008_0100);
    chk(rt, MT_WP);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_4000_0000);
    chk(rt, MT_WB);
    wr(OFF_DEF, 32'h0000_0806, RESP_OKAY);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_0000_0100);
    chk(rt, MT_WB);
    wr(OFF_VAR, 32'h1000_0006, RESP_OKAY);
    wr(OFF_VAR + 12'h008, 32'hF000_0800, RESP_OKAY);
    wr(OFF_VAR + 12'h010, 32'h1000_0004, RESP_OKAY);
    wr(OFF_VAR + 12'h018, 32'hFF00_0800, RESP_OKAY);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_1800_0000);
    chk(rt, MT_WB);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_1000_0000);
    chk(rt, MT_WT);
    wr(OFF_VAR + 12'h010, 32'h1000_0000, RESP_OKAY);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_1000_0000);
    chk(rt, MT_UC);
    wr(OFF_VAR + 12'h010, 32'h1000_0006, RESP_OKAY);
    rq(KIND_FINAL, PG_4K, 2'h0, '0, '0, 40'h00_1000_0000);
    chk(rt, MT_WB);
  endtask : t_range

  task automatic t_merge();
    mtr_mtype_t rows [5] = '{MT_UC, MT_WC, MT_WT, MT_WB, MT_WP};
    logic [31:0] v;
    logic [1:0]  e;
    for (int j = 0; j < 5; j++) begin
      wr(OFF_DEF, 32'h0000_0800 | {29'h0, rows[j]}, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
        rq(KIND_FINAL, PG_4K, 2'h0, '0, lf(i[2:0], 1'b0), 40'h00_4000_0000);
        chk(rt, rows[j]);
        chk(et, mrg(rows[j], tbl[i]));
      end
    end
    // last request: protected range, combining attribute, combining result
    rd(OFF_STAT, v, e);
    chk(v, 32'h0000_0511);
  endtask : t_merge

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_index();
    t_range();
    t_merge();
    wrap_up();
  end

  // far beyond the expected run length of a few hundred cycles
  initial begin
    #40000;
    err_count++;
    wrap_up();
  end
endmodule : tb
